// [rtl/sll_top.sv]
// Serial link lock and sync: serializer plus deserializer lock control.
// Assumes pins are synchronous to clk_i; rx_reference_clock_i is a level
// telling that the receive reference is running.
// Operation
// - Send each word with two clock bits
// - Outputs float until transmission seen and locked
// - Send sync words while either request high
// - Lock pin high unlocked, low when locked
// - Output word valid while lock pin low
// - Lose lock after four bad clock frames
// - Three words before loss are suspect
// - Lock also by searching random data
// - Request sends at least 1024 sync words
// - Edge select picks capture clock edge
// - Disable or sleep floats serial output
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module sll_top (
  input  wire logic                     clk_i,      // 100 MHz clock
  input  wire logic                     nrst_i,     // Async reset, low
  input  wire sll_pkg::sll_tx_ctrl_type tx_ctrl_i,  // Serializer pins
  input  wire logic                     tx_word_clock_i, // Word clock
  input  wire logic [9:0]               tx_data_i,  // Parallel word in
  output logic                          serial_o,   // Serial out
  output logic                          serial_oe_n_o, // Low = driving
  output logic                          tx_sync_active_o, // Sync sending
  input  wire logic                     serial_i,   // Serial in
  input  wire logic                     rx_reference_clock_i, // Ref ok
  output logic [9:0]                    rx_parallel_out_o, // Word out
  output logic                          rx_parallel_oe_n_o, // Low=drive
  output logic                          rx_word_strobe_o, // New word
  output logic                          rx_lock_n_o, // Low when locked
  input  wire logic                     reg_wr_i,   // Write strobe
  input  wire logic                     reg_rd_i,   // Read strobe
  input  wire logic [1:0]               reg_addr_i, // Register address
  input  wire logic [7:0]               reg_wdata_i, // Write data
  output logic [7:0]                    reg_rdata_o, // Read data
  output logic                          irq_o       // Interrupt level
);
  import sll_pkg::*;

  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK   = 2'h1;
  localparam logic [1:0] ADDR_STATE  = 2'h2;
  localparam int         EV_LOCK     = 0;
  localparam int         EV_LOSS     = 1;
  localparam int         EV_BAD      = 2;

  typedef struct packed {
    sll_rx_state_type  state;
    logic [2:0]        bad_cnt;
    logic [3:0]        good_cnt;
    logic              lock_n;
    logic              seen;
    logic [WORD_W-1:0] out_word;
    logic              out_stb;
    logic              out_oe_n;
    logic              slip;
    logic [2:0]        ev;
    logic [2:0]        mask;
    logic [7:0]        rdata;
  } sll_top_st_type;

  sll_top_st_type st_reg;
  sll_top_st_type st_next;
  sll_word_type   fr_word;
  logic           fr_ok;
  logic [2:0]     ev_set;

  sll_tx u_tx (
    .clk_i           (clk_i),
    .nrst_i          (nrst_i),
    .ctrl_i          (tx_ctrl_i),
    .tx_word_clock_i (tx_word_clock_i),
    .data_i          (tx_data_i),
    .serial_o        (serial_o),
    .serial_oe_n_o   (serial_oe_n_o),
    .sync_active_o   (tx_sync_active_o)
  );

  sll_rx_frame u_rx_frame (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .serial_i (serial_i),
    .slip_i   (st_reg.slip),
    .word_o   (fr_word),
    .clk_ok_o (fr_ok)
  );

  always_comb begin
    st_next         = st_reg;
    st_next.out_stb = 1'b0;
    st_next.slip    = 1'b0;
    ev_set          = 3'h0;
    case (st_reg.state)
      SLL_RX_IDLE: begin
        st_next.lock_n = 1'b1;
        if (rx_reference_clock_i && fr_word.valid) begin
          st_next.state    = SLL_RX_HUNT;
          st_next.good_cnt = 4'h0;
        end
      end
      SLL_RX_HUNT: begin
        st_next.lock_n = 1'b1;
        if (!rx_reference_clock_i) begin
          st_next.state = SLL_RX_IDLE;
        end else if (fr_word.valid) begin
          if (fr_ok) begin
            st_next.good_cnt = st_reg.good_cnt + 4'h1;
            if (st_reg.good_cnt + 4'h1 == HUNT_GOOD) begin
              st_next.state    = SLL_RX_LOCKED;
              st_next.lock_n   = 1'b0;
              st_next.seen     = 1'b1;
              st_next.out_oe_n = 1'b0;
              st_next.bad_cnt  = 3'h0;
              ev_set[EV_LOCK]  = 1'b1;
            end
          end else begin
            st_next.good_cnt = 4'h0;
            st_next.slip     = 1'b1;
          end
        end
      end
      SLL_RX_LOCKED: begin
        if (!rx_reference_clock_i) begin
          st_next.state  = SLL_RX_IDLE;
          st_next.lock_n = 1'b1;
          ev_set[EV_LOSS] = 1'b1;
        end else if (fr_word.valid) begin
          st_next.out_word = fr_word.data;
          st_next.out_stb  = 1'b1;
          if (fr_ok) begin
            st_next.bad_cnt = 3'h0;
          end else begin
            ev_set[EV_BAD]  = 1'b1;
            st_next.bad_cnt = st_reg.bad_cnt + 3'h1;
            if (st_reg.bad_cnt + 3'h1 == LOSS_COUNT) begin
              st_next.state    = SLL_RX_HUNT;
              st_next.good_cnt = 4'h0;
              st_next.lock_n   = 1'b1;
              ev_set[EV_LOSS]  = 1'b1;
            end
          end
        end
      end
      default: begin
        st_next.state  = SLL_RX_IDLE;
        st_next.lock_n = 1'b1;
      end
    endcase
    if (reg_wr_i && reg_addr_i == ADDR_MASK) begin
      st_next.mask = reg_wdata_i[2:0];
    end
    if (reg_wr_i && reg_addr_i == ADDR_STATUS) begin
      st_next.ev = (st_reg.ev & ~reg_wdata_i[2:0]) | ev_set;
    end else begin
      st_next.ev = st_reg.ev | ev_set;
    end
    st_next.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_STATUS: st_next.rdata = {5'h00, st_reg.ev};
        ADDR_MASK:   st_next.rdata = {5'h00, st_reg.mask};
        ADDR_STATE:  st_next.rdata = {st_reg.seen, st_reg.lock_n,
                                      st_reg.bad_cnt, 1'b0,
                                      st_reg.state};
        default:     st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg          <= '0;
      st_reg.state    <= SLL_RX_IDLE;
      st_reg.lock_n   <= 1'b1;
      st_reg.out_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx_parallel_out_o  = st_reg.out_word;
  assign rx_parallel_oe_n_o = st_reg.out_oe_n;
  assign rx_word_strobe_o   = st_reg.out_stb;
  assign rx_lock_n_o        = st_reg.lock_n;
  assign reg_rdata_o        = st_reg.rdata;
  assign irq_o              = |(st_reg.ev & st_reg.mask);
endmodule

// [rtl/sll_pkg.sv]
// Shared types and constants of the serial link lock and sync block.
// Assumes one clock domain; pins are synchronous to clk_i.
package sll_pkg;

  localparam int          WORD_W        = 10;
  localparam int          FRAME_BITS    = 12;
  localparam logic [3:0]  FRAME_LAST    = 4'hB;
  localparam logic [10:0] SYNC_MIN_SYMS = 11'h400;
  localparam logic [2:0]  LOSS_COUNT    = 3'h4;
  localparam logic [WORD_W-1:0] SYNC_WORD = 10'h01F;
  localparam logic [3:0]  HUNT_GOOD     = 4'h8;
  localparam logic        CLK_BIT_START = 1'h1;
  localparam logic        CLK_BIT_STOP  = 1'h0;

  typedef enum logic [1:0] {
    SLL_RX_IDLE,
    SLL_RX_HUNT,
    SLL_RX_LOCKED
  } sll_rx_state_type;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } sll_word_type;

  typedef struct packed {
    logic sync_request_a;
    logic sync_request_b;
    logic serial_out_enable;
    logic sleep_request_n;
    logic tx_strobe_edge_select;
  } sll_tx_ctrl_type;

endpackage

// [rtl/sll_tx.sv]
// Serializer: frames words with two embedded clock bits, sends sync words.
// Assumes tx_word_clock is a synchronous level sampled on clk_i.
`timescale 1ns/1ps
module sll_tx (
  input  wire logic                    clk_i,     // System clock
  input  wire logic                    nrst_i,    // Async reset, low
  input  wire sll_pkg::sll_tx_ctrl_type ctrl_i,   // Control pins
  input  wire logic                    tx_word_clock_i, // Word clock
  input  wire logic [9:0]              data_i,    // Parallel word in
  output logic                         serial_o,  // Serial bit out
  output logic                         serial_oe_n_o, // Low while driving
  output logic                         sync_active_o  // Sync words sent
);
  import sll_pkg::*;

  typedef struct packed {
    logic              clk_d;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] shift;
    logic [3:0]        bit_idx;
    logic [10:0]       sync_cnt;
    logic              in_sync;
    logic              serial;
  } sll_tx_st_type;

  sll_tx_st_type st_reg;
  sll_tx_st_type st_next;
  logic          req;
  logic          strobe;
  logic          run;

  always_comb begin
    st_next = st_reg;
    req     = ctrl_i.sync_request_a | ctrl_i.sync_request_b;
    run     = ctrl_i.sleep_request_n;
    strobe  = ctrl_i.tx_strobe_edge_select ?
              (tx_word_clock_i & ~st_reg.clk_d) :
              (~tx_word_clock_i & st_reg.clk_d);
    st_next.clk_d = tx_word_clock_i;
    if (strobe) begin
      st_next.word = data_i;
    end
    if (!run) begin
      st_next.bit_idx  = 4'h0;
      st_next.sync_cnt = 11'h000;
      st_next.in_sync  = 1'b0;
      st_next.serial   = 1'b0;
    end else begin
      if (st_reg.bit_idx == FRAME_LAST) begin
        st_next.bit_idx = 4'h0;
      end else begin
        st_next.bit_idx = st_reg.bit_idx + 4'h1;
      end
      case (st_reg.bit_idx)
        4'h0: begin
          st_next.serial = CLK_BIT_START;
          if (req || (st_reg.in_sync && st_reg.sync_cnt != 11'h000)) begin
            st_next.shift   = SYNC_WORD;
            st_next.in_sync = 1'b1;
            if (req && !st_reg.in_sync) begin
              st_next.sync_cnt = SYNC_MIN_SYMS - 11'h001;
            end else if (st_reg.sync_cnt != 11'h000) begin
              st_next.sync_cnt = st_reg.sync_cnt - 11'h001;
            end
          end else begin
            st_next.shift   = st_reg.word;
            st_next.in_sync = 1'b0;
          end
        end
        FRAME_LAST: begin
          st_next.serial = CLK_BIT_STOP;
        end
        default: begin
          st_next.serial = st_reg.shift[0];
          st_next.shift  = {1'b0, st_reg.shift[WORD_W-1:1]};
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_o      = st_reg.serial;
  assign serial_oe_n_o = ~(ctrl_i.serial_out_enable &
                           ctrl_i.sleep_request_n);
  assign sync_active_o = st_reg.in_sync;
endmodule

// [rtl/sll_rx_frame.sv]
// Deserializer bit framer: collects 12-bit frames, checks clock bits.
// Assumes the serial input is synchronous, one bit per clk_i.
`timescale 1ns/1ps
module sll_rx_frame (
  input  wire logic                 clk_i,     // System clock
  input  wire logic                 nrst_i,    // Async reset, low
  input  wire logic                 serial_i,  // Serial bit in
  input  wire logic                 slip_i,    // Skip one bit (hunt)
  output sll_pkg::sll_word_type     word_o,    // Frame word, valid pulse
  output logic                      clk_ok_o   // Clock bits valid
);
  import sll_pkg::*;

  typedef struct packed {
    logic [FRAME_BITS-1:0] sh;
    logic [3:0]            cnt;
    sll_word_type          word;
    logic                  ok;
  } sll_rf_st_type;

  sll_rf_st_type st_reg;
  sll_rf_st_type st_next;
  logic [FRAME_BITS-1:0] full;

  always_comb begin
    st_next = st_reg;
    st_next.word.valid = 1'b0;
    full = {serial_i, st_reg.sh[FRAME_BITS-1:1]};
    st_next.sh = full;
    if (slip_i) begin
      st_next.cnt = st_reg.cnt;
    end else if (st_reg.cnt == FRAME_LAST) begin
      st_next.cnt        = 4'h0;
      st_next.word.valid = 1'b1;
      st_next.word.data  = full[WORD_W:1];
      st_next.ok = (full[0] == CLK_BIT_START) &&
                   (full[FRAME_BITS-1] == CLK_BIT_STOP);
    end else begin
      st_next.cnt = st_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign word_o   = st_reg.word;
  assign clk_ok_o = st_reg.ok;
endmodule

// [test/sll_properties.sv]
// Checker on sll_top pins: tx float, sync length, rx lock and strobes.
// Assumes the single clk_i domain; bound into every sll_top.
`timescale 1ns/1ps
module sll_properties (
  input wire logic                     clk_i,              // Clock
  input wire logic                     nrst_i,             // Reset
  input wire sll_pkg::sll_tx_ctrl_type tx_ctrl_i,          // Tx pins
  input wire logic                     serial_oe_n_o,      // Tx float
  input wire logic                     tx_sync_active_o,   // Sync
  input wire logic                     rx_parallel_oe_n_o, // Rx float
  input wire logic                     rx_word_strobe_o,   // Word
  input wire logic                     rx_lock_n_o         // Lock
);
  import sll_pkg::*;
  logic [5:0]  lock_cnt_reg;
  logic [4:0]  req_cnt_reg;
  logic [13:0] sync_cnt_reg;
  logic        req_on;
  assign req_on = (tx_ctrl_i.sync_request_a | tx_ctrl_i.sync_request_b) &
                  tx_ctrl_i.sleep_request_n;
  // Saturating counts of cycles locked, requested and sending sync
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_cnt_reg <= 6'h00;
      req_cnt_reg  <= 5'h00;
      sync_cnt_reg <= 14'h0000;
    end else begin
      lock_cnt_reg <= rx_lock_n_o ? 6'h00 :
                      lock_cnt_reg + {5'h00, lock_cnt_reg != 6'h3F};
      req_cnt_reg  <= !req_on ? 5'h00 :
                      req_cnt_reg + {4'h0, req_cnt_reg != 5'h1F};
      sync_cnt_reg <= !tx_sync_active_o ? 14'h0000 :
                      sync_cnt_reg + {13'h0000, sync_cnt_reg != 14'h3FFF};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  tx_float_a: assert property (
    serial_oe_n_o == !(tx_ctrl_i.serial_out_enable &&
    tx_ctrl_i.sleep_request_n)) else $error("tx float wrong");
  rx_float_a: assert property (
    $fell(rx_parallel_oe_n_o) |-> !rx_lock_n_o || !$past(rx_lock_n_o))
    else $error("rx driven before lock");
  rx_stays_a: assert property (
    !rx_parallel_oe_n_o |=> !rx_parallel_oe_n_o) else $error("rx floats");
  strobe_locked_a: assert property (
    rx_word_strobe_o |-> !rx_lock_n_o || !$past(rx_lock_n_o))
    else $error("strobe while unlocked");
  strobe_gap_a: assert property (
    rx_word_strobe_o |=> !rx_word_strobe_o [*8]) else $error("strobe gap");
  loss_delay_a: assert property (
    $rose(rx_lock_n_o) |-> lock_cnt_reg >= 6'h2C) else $error("early loss");
  sync_start_a: assert property (
    req_on && req_cnt_reg >= 5'h10 |-> tx_sync_active_o)
    else $error("no sync on request");
  sync_len_a: assert property (
    $fell(tx_sync_active_o) && tx_ctrl_i.sleep_request_n |->
    sync_cnt_reg >= 14'h3000) else $error("sync too short");
  lock_seen_c: cover property ($fell(rx_lock_n_o));
  loss_seen_c: cover property ($rose(rx_lock_n_o));
  sync_done_c: cover property ($fell(tx_sync_active_o));
endmodule
bind sll_top sll_properties sll_properties_i (.clk_i, .nrst_i, .tx_ctrl_i,
  .serial_oe_n_o, .tx_sync_active_o, .rx_parallel_oe_n_o,
  .rx_word_strobe_o, .rx_lock_n_o);

// [test/sll_peer.sv]
// Peer serializer: sends frames whose words have at most one 1-to-0 edge.
// Assumes one bit per clk_i; bad_i flips both clock bits of a frame.
`timescale 1ns/1ps
module sll_peer (
  input  wire logic clk_i,    // Clock
  input  wire logic nrst_i,   // Reset, low
  input  wire logic bad_i,    // Corrupt next frame
  output logic      serial_o  // Serial bit
);
  import sll_pkg::*;
  logic [3:0]        bit_reg;
  logic [WORD_W-1:0] word_reg;
  logic [11:0]       frame_reg;
  assign serial_o = frame_reg[0];
  // Thermometer words leave a single true frame alignment in the stream
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_reg   <= 4'h0;
      word_reg  <= 10'h3FF;
      frame_reg <= 12'h000;
    end else if (bit_reg == FRAME_LAST) begin
      bit_reg   <= 4'h0;
      word_reg  <= (word_reg == 10'h000) ? 10'h3FF : word_reg >> 1;
      frame_reg <= {bad_i, word_reg, !bad_i};
    end else begin
      bit_reg   <= bit_reg + 4'h1;
      frame_reg <= {1'b0, frame_reg[11:1]};
    end
  end
endmodule

// [test/tb_sll_top.sv]
// Bench for sll_top: register port tasks, peer model on serial_i.
// Assumes a 100 MHz clock; checks are made at falling edges.
`timescale 1ns/1ps
module tb_sll_top;
  import sll_pkg::*;
  logic            clk_i = 1'b0, nrst_i = 1'b0, bad = 1'b0;
  sll_tx_ctrl_type tx_ctrl_i = 5'h06;
  logic            tx_word_clock_i = 1'b0, rx_reference_clock_i = 1'b1;
  logic            reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [1:0]      reg_addr_i = 2'h0;
  logic [7:0]      reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic [9:0]      tx_data_i = 10'h000, rx_parallel_out_o, w0, w1;
  logic            serial_i, serial_o, serial_oe_n_o, tx_sync_active_o;
  logic            rx_parallel_oe_n_o, rx_word_strobe_o, rx_lock_n_o, irq_o;
  logic [11:0]     f;
  int              num_errors = 0, total_checks = 0, cycles = 0, n;

  sll_top  sll_top_i (.*);
  sll_peer sll_peer_i (.clk_i, .nrst_i, .bad_i(bad), .serial_o(serial_i));

  initial forever #5 clk_i = ~clk_i;

  task check(input string nm, input logic [13:0] s, input logic [13:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task results;
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_o;
  endtask
  task wait_lock;
    n = 0;
    while (rx_lock_n_o !== 1'b0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check("lock_n", rx_lock_n_o, 1'b0);
    check("rx oe_n", rx_parallel_oe_n_o, 1'b0);
  endtask
  task next_word(output logic [9:0] w);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rx_word_strobe_o !== 1'b1 && n < 40);
    check("strobe", rx_word_strobe_o, 1'b1);
    w = rx_parallel_out_o;
  endtask
  task word_pair;
    next_word(w0);
    next_word(w1);
    check("word", w1, (w0 == 10'h000) ? 10'h3FF : w0 >> 1);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    check("lock_n", rx_lock_n_o, 1'b1);
    check("rx oe_n", rx_parallel_oe_n_o, 1'b1);
    @(posedge clk_i);
    tx_ctrl_i.serial_out_enable <= 1'b0;
    @(negedge clk_i);
    check("tx oe_n", serial_oe_n_o, 1'b1);
    @(posedge clk_i);
    tx_ctrl_i.serial_out_enable <= 1'b1;
    wait_lock();
    wr(2'h0, 8'hFF);
    wr(2'h1, 8'h02);
    word_pair();
    rd(2'h2, d);
    check("state", d, 8'h82);
    rd(2'h1, d);
    check("mask", d, 8'h02);
    // Three bad frames keep lock, a longer run loses it
    @(posedge clk_i);
    bad <= 1'b1;
    repeat (36) @(posedge clk_i);
    bad <= 1'b0;
    repeat (60) @(negedge clk_i);
    check("lock_n", rx_lock_n_o, 1'b0);
    check("irq", irq_o, 1'b0);
    rd(2'h0, d);
    check("status bad", d & 8'h04, 8'h04);
    @(posedge clk_i);
    bad <= 1'b1;
    repeat (72) @(negedge clk_i);
    check("lock_n", rx_lock_n_o, 1'b1);
    check("irq", irq_o, 1'b1);
    rd(2'h0, d);
    check("status", d & 8'h02, 8'h02);
    rd(2'h3, d);
    check("unmapped", d, 8'h00);
    wr(2'h0, 8'h02);
    repeat (2) @(negedge clk_i);
    check("irq", irq_o, 1'b0);
    @(posedge clk_i);
    bad <= 1'b0;
    wait_lock();
    word_pair();
    // Sync burst; a word is latched on the falling word clock meanwhile
    @(posedge clk_i);
    tx_ctrl_i.sync_request_b <= 1'b1;
    n = 0;
    while (tx_sync_active_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    while (tx_sync_active_o === 1'b1 && n < 20000) begin
      if (n < 12) f[n] = serial_o;
      @(posedge clk_i);
      if (n == 20) tx_ctrl_i.sync_request_b <= 1'b0;
      if (n == 40) {tx_word_clock_i, tx_data_i} <= {1'b1, 10'h155};
      if (n == 44) {tx_word_clock_i, tx_data_i} <= {1'b0, 10'h2A6};
      @(negedge clk_i);
      n++;
    end
    check("sync frame", f, {1'b0, SYNC_WORD, 1'b1});
    check("sync cycles", 14'(n >= 12288), 14'h0001);
    check("sync end", tx_sync_active_o, 1'b0);
    for (int i = 0; i < 12; i++) begin
      f[i] = serial_o;
      @(negedge clk_i);
    end
    check("data frame", f, {1'b0, 10'h2A6, 1'b1});
    // Rising strobe selected: 0C3 is taken, 3C0 after the fall is not
    @(posedge clk_i);
    tx_ctrl_i.tx_strobe_edge_select <= 1'b1;
    {tx_word_clock_i, tx_data_i} <= {1'b1, 10'h0C3};
    @(posedge clk_i);
    {tx_word_clock_i, tx_data_i} <= {1'b0, 10'h3C0};
    repeat (11) @(negedge clk_i);
    for (int i = 0; i < 12; i++) begin
      f[i] = serial_o;
      @(negedge clk_i);
    end
    check("rise frame", f, {1'b0, 10'h0C3, 1'b1});
    // Reference stops: lock drops at once, then returns by itself
    @(posedge clk_i);
    rx_reference_clock_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check("lock_n", rx_lock_n_o, 1'b1);
    check("irq", irq_o, 1'b1);
    @(posedge clk_i);
    rx_reference_clock_i <= 1'b1;
    wait_lock();
    // Lock pin looped onto a sync request restarts sync on loss
    @(posedge clk_i);
    bad <= 1'b1;
    repeat (100) begin
      @(posedge clk_i);
      tx_ctrl_i.sync_request_a <= rx_lock_n_o;
    end
    @(negedge clk_i);
    check("loop sync", tx_sync_active_o, 1'b1);
    @(posedge clk_i);
    tx_ctrl_i.sleep_request_n <= 1'b0;
    repeat (3) @(negedge clk_i);
    check("sleep serial", serial_o, 1'b0);
    check("sleep oe_n", serial_oe_n_o, 1'b1);
    results;
  end
endmodule
